// >>> src/lic_line_loop_ctrl.sv
// line interface configuration and diagnostic loopback control
// assumes APB master on the same clock; modem status inputs synchronous
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module lic_line_loop_ctrl #(
   parameter int NLINES = 4,
   parameter longint unsigned MINUTE_CYCLES = lic_pkg::CYCLES_PER_MIN,
   parameter bit SUBBAND_EXEMPT = 1'b0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // radio side
   input wire logic sameSubBand,
   input wire logic farAck,
   input wire logic farFail,
   output logic rxTuneToTx,
   output logic localDigitalLoop,
   output logic farEchoReq,
   // line side
   output logic [NLINES-1:0] payloadOn,
   output lic_pkg::lic_line_s [NLINES-1:0] lineCfg,
   output logic [2*NLINES-1:0] lineSpan,
   output logic [NLINES-1:0] lineLoopLocal,
   output logic [NLINES-1:0] farSpanLoop,
   output logic [NLINES-1:0] errInit,
   output logic e1Mode,
   output logic irq
);
   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic setup;
   logic access;
   logic wrEn;
   logic mapped;
   logic [31:0] rdData;
   assign setup = psel & ~penable;
   assign access = psel & penable & pready;
   assign wrEn = access & pwrite & ~pslverr;
   // address decode, unmapped offsets answer with slverr
   always_comb begin
      mapped = 1'b0;
      case (paddr)
         lic_pkg::CTRL_OFF, lic_pkg::LINECFG_OFF, lic_pkg::LINEMAP_OFF,
         lic_pkg::LINELOOP_OFF, lic_pkg::LINERR_OFF, lic_pkg::STATUS_OFF,
         lic_pkg::IRQSTAT_OFF, lic_pkg::IRQMASK_OFF: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   logic fracMode_q;
   logic e1Mode_q;
   logic [5:0] tmoMin_q;
   logic [NLINES-1:0] loopLocal_q;
   logic [NLINES-1:0] loopRemote_q;
   logic [NLINES-1:0] linErrOn_q;
   logic [NLINES-1:0] errInit_q;
   lic_pkg::lic_line_s [NLINES-1:0] lineCfg_q;
   logic [2*NLINES-1:0] lineMap_q;
   logic [lic_pkg::IRQ_W-1:0] irqStat_q;
   logic [lic_pkg::IRQ_W-1:0] irqMask_q;
   logic [lic_pkg::IRQ_W-1:0] irqSet;
   logic goReq;
   lic_pkg::lic_mode_e reqMode;
   logic [5:0] wrTmo;
   logic [5:0] goTmo;
   assign goReq = wrEn && paddr == lic_pkg::CTRL_OFF && pwdata[lic_pkg::CTRL_GO_BIT];
   assign reqMode = lic_pkg::lic_mode_e'(pwdata[lic_pkg::CTRL_MODE_LSB +: 2]);
   assign wrTmo = pwdata[lic_pkg::CTRL_TMO_LSB +: 6];
   assign goTmo = wrTmo <= lic_pkg::MAX_TIMEOUT_MIN ? wrTmo : tmoMin_q;
   // global mode bits and timeout, out-of-range timeout kept old
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fracMode_q <= 1'b0;
         e1Mode_q <= 1'b0;
         tmoMin_q <= lic_pkg::TMO_RST;
      end else if (ce && wrEn && paddr == lic_pkg::CTRL_OFF) begin
         fracMode_q <= pwdata[lic_pkg::CTRL_FRAC_BIT];
         e1Mode_q <= pwdata[lic_pkg::CTRL_E1_BIT];
         if (wrTmo <= lic_pkg::MAX_TIMEOUT_MIN) begin
            tmoMin_q <= wrTmo;
         end
      end
   end

   // line loop selection and error measurement switches
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         loopLocal_q <= '0;
         loopRemote_q <= '0;
         linErrOn_q <= '0;
         errInit_q <= '0;
      end else if (ce) begin
         errInit_q <= '0;
         if (wrEn && paddr == lic_pkg::LINELOOP_OFF) begin
            loopLocal_q <= pwdata[NLINES-1:0];
            loopRemote_q <= pwdata[2*NLINES-1:NLINES];
         end
         if (wrEn && paddr == lic_pkg::LINERR_OFF) begin
            linErrOn_q <= pwdata[NLINES-1:0];
            errInit_q <= pwdata[NLINES-1:0] & ~linErrOn_q;
         end
      end
   end

   // per line code, cable template and span mapping
   genvar gi;
   generate
      for (gi = 0; gi < NLINES; gi++) begin : g_line
         logic [7:0] wrField;
         logic [1:0] wrSpan;
         assign wrField = pwdata[gi*lic_pkg::LCFG_STRIDE +: 8];
         assign wrSpan = pwdata[gi*lic_pkg::LMAP_STRIDE +: 2];
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               lineCfg_q[gi] <= lic_pkg::LINE_RST;
               lineMap_q[gi*lic_pkg::LMAP_STRIDE +: 2] <= 2'(gi);
            end else if (ce) begin
               if (wrEn && paddr == lic_pkg::LINECFG_OFF) begin
                  lineCfg_q[gi].codeAlt <= wrField[0];
                  lineCfg_q[gi].specAlt <= wrField[1];
                  if (wrField[4:2] <= lic_pkg::MAX_CABLE_LEN) begin
                     lineCfg_q[gi].cableLen <= wrField[4:2];
                  end
               end
               // a pair is applied only when its valid bit is set
               if (wrEn && paddr == lic_pkg::LINEMAP_OFF && pwdata[16+gi]) begin
                  lineMap_q[gi*lic_pkg::LMAP_STRIDE +: 2] <= wrSpan;
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // loopback state machine
   // ------------------------------------------------------------
   lic_pkg::lic_state_e state_q;
   lic_pkg::lic_mode_e mode_q;
   logic [5:0] minLeft_q;
   logic timed_q;
   logic [35:0] cycCnt_q;
   logic minuteTick;
   logic expire;
   logic radioOk;
   assign radioOk = sameSubBand | SUBBAND_EXEMPT;
   assign minuteTick = cycCnt_q == 36'(MINUTE_CYCLES - 1);
   assign expire = state_q == lic_pkg::ST_ACTIVE && timed_q && minuteTick &&
      minLeft_q == 6'h01;
   // mode transitions on a go write, far answer or timeout
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q <= lic_pkg::ST_IDLE;
         mode_q <= lic_pkg::LB_NONE;
      end else if (ce) begin
         if (goReq) begin
            case (reqMode)
               lic_pkg::LB_NONE: begin
                  state_q <= lic_pkg::ST_IDLE;
                  mode_q <= lic_pkg::LB_NONE;
               end
               lic_pkg::LB_RADIO: begin
                  if (radioOk) begin
                     state_q <= lic_pkg::ST_ACTIVE;
                     mode_q <= lic_pkg::LB_RADIO;
                  end
               end
               lic_pkg::LB_LOCAL: begin
                  state_q <= lic_pkg::ST_ACTIVE;
                  mode_q <= lic_pkg::LB_LOCAL;
               end
               lic_pkg::LB_REMOTE: begin
                  state_q <= lic_pkg::ST_RSETUP;
                  mode_q <= lic_pkg::LB_NONE;
               end
               default: state_q <= lic_pkg::ST_IDLE;
            endcase
         end else begin
            case (state_q)
               lic_pkg::ST_RSETUP: begin
                  if (farFail) begin
                     state_q <= lic_pkg::ST_IDLE;
                     mode_q <= lic_pkg::LB_NONE;
                  end else if (farAck) begin
                     state_q <= lic_pkg::ST_ACTIVE;
                     mode_q <= lic_pkg::LB_REMOTE;
                  end
               end
               lic_pkg::ST_ACTIVE: begin
                  if (expire) begin
                     state_q <= lic_pkg::ST_IDLE;
                     mode_q <= lic_pkg::LB_NONE;
                  end
               end
               lic_pkg::ST_IDLE: mode_q <= lic_pkg::LB_NONE;
               default: state_q <= lic_pkg::ST_IDLE;
            endcase
         end
      end
   end
   // minute timer, loaded when a go write is taken
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cycCnt_q <= '0;
         minLeft_q <= '0;
         timed_q <= 1'b0;
      end else if (ce) begin
         if (goReq) begin
            cycCnt_q <= '0;
            minLeft_q <= goTmo;
            timed_q <= goTmo != 6'h00;
         end else if (state_q == lic_pkg::ST_ACTIVE && timed_q) begin
            if (minuteTick) begin
               cycCnt_q <= '0;
               minLeft_q <= minLeft_q - 6'h01;
            end else begin
               cycCnt_q <= cycCnt_q + 36'h1;
            end
         end
      end
   end
   // ------------------------------------------------------------
   // interrupt status and mask
   // ------------------------------------------------------------
   always_comb begin
      irqSet = '0;
      irqSet[lic_pkg::IRQ_REMERR] = state_q == lic_pkg::ST_RSETUP && farFail && !goReq;
      irqSet[lic_pkg::IRQ_TIMEOUT] = expire && !goReq;
      irqSet[lic_pkg::IRQ_REFUSED] = goReq && reqMode == lic_pkg::LB_RADIO && !radioOk;
      irqSet[lic_pkg::IRQ_REMOK] = state_q == lic_pkg::ST_RSETUP && farAck && !farFail &&
         !goReq;
   end
   // write one clears, a new event in the same cycle wins
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irqStat_q <= '0;
         irqMask_q <= lic_pkg::IRQMASK_RST;
         irq <= 1'b0;
      end else if (ce) begin
         if (wrEn && paddr == lic_pkg::IRQSTAT_OFF) begin
            irqStat_q <= (irqStat_q & ~pwdata[lic_pkg::IRQ_W-1:0]) | irqSet;
         end else begin
            irqStat_q <= irqStat_q | irqSet;
         end
         if (wrEn && paddr == lic_pkg::IRQMASK_OFF) begin
            irqMask_q <= pwdata[lic_pkg::IRQ_W-1:0];
         end
         irq <= |(irqStat_q & irqMask_q);
      end
   end

   // ------------------------------------------------------------
   // registered outputs toward radio and lines
   // ------------------------------------------------------------
   logic [NLINES-1:0] spanMask;
   logic [NLINES-1:0] lineLoopOn;
   logic [1:0] effSpan [NLINES];

   // effective span per line and far span mask of remote line loops
   always_comb begin
      spanMask = '0;
      for (int i = 0; i < NLINES; i++) begin
         effSpan[i] = fracMode_q ? 2'h0 : lineMap_q[i*lic_pkg::LMAP_STRIDE +: 2];
         if (fracMode_q && loopRemote_q[i]) begin
            spanMask[effSpan[i]] = 1'b1;
         end
      end
      lineLoopOn = fracMode_q ? (loopLocal_q | loopRemote_q) : '0;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rxTuneToTx <= 1'b0;
         localDigitalLoop <= 1'b0;
         farEchoReq <= 1'b0;
         payloadOn <= '0;
         lineLoopLocal <= '0;
         farSpanLoop <= '0;
      end else if (ce) begin
         rxTuneToTx <= mode_q == lic_pkg::LB_RADIO;
         localDigitalLoop <= mode_q == lic_pkg::LB_LOCAL;
         farEchoReq <= state_q == lic_pkg::ST_RSETUP || mode_q == lic_pkg::LB_REMOTE;
         payloadOn <= state_q == lic_pkg::ST_IDLE ? ~lineLoopOn : '0;
         lineLoopLocal <= fracMode_q ? loopLocal_q : '0;
         farSpanLoop <= spanMask;
      end
   end
   // line template, span and error init toward the line drivers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lineCfg <= '0;
         lineSpan <= '0;
         errInit <= '0;
         e1Mode <= 1'b0;
      end else if (ce) begin
         for (int i = 0; i < NLINES; i++) begin
            lineCfg[i].codeAlt <= lineCfg_q[i].codeAlt;
            lineCfg[i].specAlt <= lineCfg_q[i].specAlt;
            lineCfg[i].cableLen <= e1Mode_q ? 3'h0 : lineCfg_q[i].cableLen;
            lineSpan[i*2 +: 2] <= effSpan[i];
         end
         errInit <= errInit_q;
         e1Mode <= e1Mode_q;
      end
   end

   // ------------------------------------------------------------
   // read mux, side-effect free
   // ------------------------------------------------------------
   always_comb begin
      rdData = '0;
      case (paddr)
         lic_pkg::CTRL_OFF: begin
            rdData[lic_pkg::CTRL_MODE_LSB +: 2] = mode_q;
            rdData[lic_pkg::CTRL_FRAC_BIT] = fracMode_q;
            rdData[lic_pkg::CTRL_E1_BIT] = e1Mode_q;
            rdData[lic_pkg::CTRL_TMO_LSB +: 6] = tmoMin_q;
         end
         lic_pkg::LINECFG_OFF: begin
            for (int i = 0; i < NLINES; i++) begin
               rdData[i*lic_pkg::LCFG_STRIDE +: 5] = lineCfg_q[i];
            end
         end
         lic_pkg::LINEMAP_OFF: rdData[2*NLINES-1:0] = lineMap_q;
         lic_pkg::LINELOOP_OFF: rdData[2*NLINES-1:0] = {loopRemote_q, loopLocal_q};
         lic_pkg::LINERR_OFF: rdData[NLINES-1:0] = linErrOn_q;
         lic_pkg::STATUS_OFF: begin
            rdData[1:0] = mode_q;
            rdData[3:2] = state_q;
            rdData[4] = timed_q;
            rdData[13:8] = minLeft_q;
         end
         lic_pkg::IRQSTAT_OFF: rdData[lic_pkg::IRQ_W-1:0] = irqStat_q;
         lic_pkg::IRQMASK_OFF: rdData[lic_pkg::IRQ_W-1:0] = irqMask_q;
         default: rdData = '0;
      endcase
   end
   // no wait state: data and ready set up during the setup cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else if (ce) begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rdData;
         end
      end
   end

endmodule // lic_line_loop_ctrl

// >>> src/lic_pkg.sv
// constants, types and field layout of the line interface loopback block
// assumes a 200 MHz clock and a 32-bit APB register bus
package lic_pkg;
   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] LINECFG_OFF = 8'h04;
   localparam logic [7:0] LINEMAP_OFF = 8'h08;
   localparam logic [7:0] LINELOOP_OFF = 8'h0C;
   localparam logic [7:0] LINERR_OFF = 8'h10;
   localparam logic [7:0] STATUS_OFF = 8'h14;
   localparam logic [7:0] IRQSTAT_OFF = 8'h18;
   localparam logic [7:0] IRQMASK_OFF = 8'h1C;
   // ------------------------------------------------------------
   // field positions and limits
   // ------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_FRAC_BIT = 2;
   localparam int CTRL_E1_BIT = 3;
   localparam int CTRL_GO_BIT = 4;
   localparam int CTRL_TMO_LSB = 8;
   localparam int LCFG_STRIDE = 8;
   localparam int LMAP_STRIDE = 2;
   localparam logic [2:0] MAX_CABLE_LEN = 3'h4;
   localparam logic [5:0] MAX_TIMEOUT_MIN = 6'h3C;
   localparam int IRQ_REMERR = 0;
   localparam int IRQ_TIMEOUT = 1;
   localparam int IRQ_REFUSED = 2;
   localparam int IRQ_REMOK = 3;
   localparam int IRQ_W = 4;
   // ------------------------------------------------------------
   // reset values and timing
   // ------------------------------------------------------------
   localparam logic [5:0] TMO_RST = 6'h00;
   localparam logic [IRQ_W-1:0] IRQMASK_RST = 4'h0;
   localparam longint unsigned MINUTE_S = 60;
   localparam longint unsigned CLOCK_HZ = 200_000_000;
   localparam longint unsigned CYCLES_PER_MIN = MINUTE_S * CLOCK_HZ;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      LB_NONE = 2'b00, LB_RADIO = 2'b01, LB_LOCAL = 2'b10, LB_REMOTE = 2'b11
   } lic_mode_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_ACTIVE = 2'b01, ST_RSETUP = 2'b10
   } lic_state_e;
   typedef struct packed {
      logic codeAlt;        // 0 AMI, 1 B8ZS (T1) or HDB3 (E1)
      logic specAlt;        // 0 first standard, 1 second
      logic [2:0] cableLen; // T1 template band, zero on E1
   } lic_line_s;
   localparam lic_line_s LINE_RST = '{codeAlt: 1'b0, specAlt: 1'b0, cableLen: 3'h0};
endpackage

// >>> sim/lic_ctrl_props.sv
// port assertions for the line loop controller
// assumes one clock domain, bound onto every controller instance
`timescale 1ns/100ps
module lic_ctrl_props #(
   parameter int NLINES = 4,
   parameter bit SUBBAND_EXEMPT = 1'b0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sameSubBand,
   input wire logic farAck,
   input wire logic farFail,
   input wire logic rxTuneToTx,
   input wire logic localDigitalLoop,
   input wire logic farEchoReq,
   input wire logic [NLINES-1:0] payloadOn,
   input wire lic_pkg::lic_line_s [NLINES-1:0] lineCfg,
   input wire logic [NLINES-1:0] errInit,
   input wire logic e1Mode
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   logic lenOk;
   logic [2:0] lenOr;
   logic errWr;
   logic ackSeen_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // cable bands of all lines
   always_comb begin
      lenOk = 1'b1;
      lenOr = 3'h0;
      for (int i = 0; i < NLINES; i++) begin
         lenOr = lenOr | lineCfg[i].cableLen;
         if (lineCfg[i].cableLen > lic_pkg::MAX_CABLE_LEN) begin
            lenOk = 1'b0;
         end
      end
   end
   // completed write to the error measurement mask
   assign errWr = psel && penable && pready && pwrite && paddr == lic_pkg::LINERR_OFF;
   // far answer already taken during this echo request
   always_ff @(posedge clock) begin
      ackSeen_q <= rst_n && farEchoReq && (ackSeen_q || farAck);
   end
   sequence apbSetup;
      psel && !penable && ce;
   endsequence
   sequence oneAccess;
      pready ##1 !pready;
   endsequence
   sequence farFailInSetup;
      farEchoReq && farFail && !ackSeen_q;
   endsequence
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   AST_APB_ANSWER: assert property (apbSetup |=> oneAccess)
      else $error("apb access not answered in one cycle");
   AST_SLVERR_QUAL: assert property (pslverr |-> pready)
      else $error("error response outside access");
   AST_LOOP_STOPS_PAYLOAD: assert property ((rxTuneToTx || localDigitalLoop || farEchoReq)
      |-> payloadOn == '0)
      else $error("payload passes during loopback");
   AST_ONE_LOOP_PATH: assert property ($onehot0({rxTuneToTx, localDigitalLoop, farEchoReq}))
      else $error("several loop paths at once");
   AST_SUBBAND: assert property ($rose(rxTuneToTx) |-> SUBBAND_EXEMPT || $past(sameSubBand, 2))
      else $error("radio loop outside sub-band");
   AST_FAR_FAIL: assert property (farFailInSetup |-> ##2 !farEchoReq)
      else $error("remote request kept after far failure");
   AST_ERR_INIT: assert property (|errInit |-> $past(errWr) || $past(errWr, 2))
      else $error("error measurement start without write");
   AST_E1_NO_LEN: assert property (e1Mode && $past(e1Mode) |-> lenOr == 3'h0)
      else $error("cable band set on e1 line");
   AST_LEN_RANGE: assert property (lenOk)
      else $error("cable band above table");
endmodule // lic_ctrl_props
bind lic_line_loop_ctrl lic_ctrl_props #(.NLINES(NLINES), .SUBBAND_EXEMPT(SUBBAND_EXEMPT))
   u_lic_ctrl_props (.clock, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pready,
   .pslverr, .sameSubBand, .farAck, .farFail, .rxTuneToTx, .localDigitalLoop, .farEchoReq,
   .payloadOn, .lineCfg, .errInit, .e1Mode);

// >>> sim/lic_far_radio.sv
// far-end radio model answering remote echo requests
// assumes same clock as the controller; answer settings come from the bench
`timescale 1ns/100ps
module lic_far_radio (
   input wire logic clock,
   input wire logic farEchoReq,
   input wire logic answerFail,
   input wire logic [3:0] answerDelay,
   output logic farAck,
   output logic farFail
);
   int cnt = 0;
   initial begin
      farAck = 1'b0;
      farFail = 1'b0;
   end
   // echo granted or refused once, after a chosen delay
   always @(posedge clock) begin
      if (farEchoReq !== 1'b1) begin
         cnt <= 0;
         farAck <= 1'b0;
         farFail <= 1'b0;
      end else begin
         cnt <= cnt + 1;
         farFail <= answerFail && cnt == answerDelay;
         if (!answerFail && cnt == answerDelay) begin
            farAck <= 1'b1;
         end
      end
   end
endmodule // lic_far_radio

// >>> sim/lic_line_loop_ctrl_tb.sv
// self-checking bench for the line loop controller
// assumes far radio model and bound checker; short minute for sim
`timescale 1ns/100ps
module lic_line_loop_ctrl_tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, rerr, farAck, farFail, rxTuneToTx, localDigitalLoop, farEchoReq;
   logic sameSubBand = 1'b1, answerFail = 1'b0, e1Mode, irq, errClr = 1'b0;
   logic [3:0] answerDelay = 4'h1, payloadOn, lineLoopLocal, farSpanLoop, errInit, errSeen;
   logic [7:0] lineSpan;
   lic_pkg::lic_line_s [3:0] lineCfg;
   int n_errors = 0, compares = 0, cyc = 0, expMode = 0, expIrq = 0, n;
   int c[4], s[4], l[4], sp[4];
   logic [31:0] v;
   lic_line_loop_ctrl #(.NLINES(4), .MINUTE_CYCLES(20), .SUBBAND_EXEMPT(1'b0))
      u_lic_line_loop_ctrl (.clock, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sameSubBand, .farAck, .farFail, .rxTuneToTx,
      .localDigitalLoop, .farEchoReq, .payloadOn, .lineCfg, .lineSpan, .lineLoopLocal,
      .farSpanLoop, .errInit, .e1Mode, .irq);
   lic_far_radio u_lic_far_radio (.clock, .farEchoReq, .answerFail, .answerDelay, .farAck,
      .farFail);
   // clock, hang guard and error pulse capture
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      errSeen <= errClr ? 4'h0 : errSeen | errInit;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic report_and_stop();
      if (n_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
   endtask
   task automatic go(input int m, input int t);
      apb(1'b1, lic_pkg::CTRL_OFF, (t << 8) | 32'h10 | m);
      if (!(m == 1 && !sameSubBand) && m != 3) expMode = m;
      tick(3);
   endtask
   task automatic st();
      apb(1'b0, lic_pkg::STATUS_OFF, 32'h0);
      chk(rdat[1:0], expMode);
      apb(1'b0, lic_pkg::IRQSTAT_OFF, 32'h0);
      chk(rdat, expIrq);
      apb(1'b1, lic_pkg::IRQSTAT_OFF, expIrq);
      expIrq = 0;
   endtask
   task automatic waitOn(input logic want);
      while (farEchoReq !== want) begin
         @(posedge clock);
      end
      tick(3);
   endtask
   function automatic logic [7:0] spanv();
      return {sp[3][1:0], sp[2][1:0], sp[1][1:0], sp[0][1:0]};
   endfunction
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h673CFFCA));
      tick(8);
      rst_n <= 1'b1;
      tick(2);
      for (int i = 0; i < 4; i++) sp[i] = i;
      chk(lineSpan, spanv());
      apb(1'b0, lic_pkg::CTRL_OFF, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b0, lic_pkg::LINECFG_OFF, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({rerr, rdat}, {1'b1, 32'h0});
      v = 0;
      for (int i = 0; i < 4; i++) begin
         c[i] = $urandom_range(1, 0);
         s[i] = $urandom_range(1, 0);
         l[i] = $urandom_range(4, 0);
         v = v | ((c[i] | (s[i] << 1) | (l[i] << 2)) << (8 * i));
      end
      apb(1'b1, lic_pkg::LINECFG_OFF, v);
      apb(1'b1, lic_pkg::LINECFG_OFF, v | 32'h14); // len 5 or 7 on line 0 must be kept out
      tick(2);
      for (int i = 0; i < 4; i++) chk(lineCfg[i], {c[i][0], s[i][0], l[i][2:0]});
      apb(1'b1, lic_pkg::CTRL_OFF, 32'h8);
      tick(2);
      chk(e1Mode, 1'b1);
      for (int i = 0; i < 4; i++) chk(lineCfg[i], {c[i][0], s[i][0], 3'h0});
      v = 32'hF0000;
      for (int i = 0; i < 4; i++) begin
         sp[i] = $urandom_range(3, 0);
         v = v | (sp[i] << (2 * i));
      end
      apb(1'b1, lic_pkg::LINEMAP_OFF, v);
      n = $urandom_range(3, 0);
      sp[n] = 3 - sp[n];
      apb(1'b1, lic_pkg::LINEMAP_OFF, (1 << (16 + n)) | (sp[n] << (2 * n)));
      tick(2);
      chk(lineSpan, spanv());
      apb(1'b1, lic_pkg::CTRL_OFF, 32'h4);
      apb(1'b1, lic_pkg::LINELOOP_OFF, 32'h42);
      tick(2);
      chk(lineSpan, 8'h00);
      chk({lineLoopLocal, farSpanLoop, payloadOn}, 12'h219);
      apb(1'b1, lic_pkg::LINELOOP_OFF, 32'h0);
      apb(1'b1, lic_pkg::CTRL_OFF, 32'h0);
      tick(2);
      chk(lineSpan, spanv());
      for (int m = 1; m < 3; m++) begin
         go(m, 0);
         chk({rxTuneToTx, localDigitalLoop, payloadOn}, {m == 1, m == 2, 4'h0});
         st();
         st();
         go(0, 0);
         chk({rxTuneToTx, localDigitalLoop, farEchoReq, payloadOn}, 7'h0F);
      end
      sameSubBand <= 1'b0;
      tick(1);
      go(1, 0);
      chk({rxTuneToTx, irq}, 2'b00);
      apb(1'b1, lic_pkg::IRQMASK_OFF, 32'h4);
      tick(2);
      chk(irq, 1'b1);
      expIrq = 4;
      st();
      tick(2);
      chk(irq, 1'b0);
      sameSubBand <= 1'b1;
      for (int f = 0; f < 2; f++) begin
         answerFail <= f;
         answerDelay <= $urandom_range(6, 1);
         go(3, 0);
         waitOn(f ? 1'b0 : 1'b1);
         waitOn(f ? 1'b0 : 1'b1);
         chk(farEchoReq, !f);
         expMode = f ? 0 : 3;
         expIrq = f ? 1 : 8;
         st();
         go(0, 0);
      end
      go(2, 2);
      tick(26);
      chk(localDigitalLoop, 1'b1);
      ce <= 1'b0;
      tick(20);
      ce <= 1'b1;
      tick(3);
      chk(localDigitalLoop, 1'b1);
      tick(20);
      chk({localDigitalLoop, payloadOn}, 5'h0F);
      expMode = 0;
      expIrq = 2;
      st();
      apb(1'b1, lic_pkg::CTRL_OFF, 32'd61 << 8);
      apb(1'b0, lic_pkg::CTRL_OFF, 32'h0);
      chk(rdat[13:8], 6'd2);
      go(2, 0);
      tick(100);
      chk(localDigitalLoop, 1'b1);
      go(0, 0);
      for (int k = 0; k < 2; k++) begin
         errClr <= 1'b1;
         tick(1);
         errClr <= 1'b0;
         apb(1'b1, lic_pkg::LINERR_OFF, k ? 32'h7 : 32'h5);
         tick(2);
         chk(errSeen, k ? 4'h2 : 4'h5);
      end
      report_and_stop();
   end
endmodule // lic_line_loop_ctrl_tb
